// ### design/tm16_counter_core.sv
// 16-bit timer counter core with byte-wide host access and shared staging byte
`timescale 1ns/1ps
`default_nettype none
module tm16_counter_core
   import tm16_pkg::*;
(
   input  wire logic        ref_clk,           // system clock, 250 MHz
   input  wire logic        rst,               // async reset, active high
   input  wire logic        timer_power_off,   // high holds the timer disabled
   input  wire logic [3:0]  bus_addr,          // byte location
   input  wire logic        bus_wr,            // byte write strobe
   input  wire logic        bus_rd,            // byte read strobe
   input  wire logic [7:0]  bus_wdata,         // write data
   input  wire logic        ext_pin,           // external timer clock
   input  wire logic        capture_event,     // capture strobe from outside
   output logic [7:0]       bus_rdata,         // read data, one cycle after read
   output logic             overflow_flag,     // one-cycle overflow pulse
   output logic [15:0]      count_value        // live counter value
);
   logic [7:0]  control_a_r;      // control a
   logic [7:0]  control_b_r;      // control b
   logic [7:0]  staging_r;        // shared high-byte staging register
   logic [15:0] count_r;          // counter
   logic [15:0] compare_a_r;      // compare value a
   logic [15:0] compare_b_r;      // compare value b
   logic [15:0] capture_r;        // capture value
   logic        dir_down_r;       // counting down in dual-slope modes
   logic [7:0]  rdata_r;          // read data register
   logic        ovf_r;            // overflow pulse register
   logic        timer_tick;       // tick enable from generator
   logic        enabled;          // module powered
   logic [3:0]  waveform_mode;    // combined mode field
   logic [15:0] top_value;        // top of current sequence
   logic        dual_slope;       // up-down counting mode
   logic        fast_mode;        // single slope with overflow at top
   logic        capture_is_top;   // capture register defines top
   logic        wr_count_low;     // host loads the counter

   // power gating: a set power-off bit freezes ticks and ignores every access
   assign enabled      = ~timer_power_off;
   // waveform mode bits live in both control registers
   assign waveform_mode = {control_b_r[TM16_WGM_B_LSB+1 -: 2],
                           control_a_r[TM16_WGM_A_LSB+1 -: 2]};
   // taken low write of the count; it outranks any tick in the same cycle
   assign wr_count_low = enabled & bus_wr & (bus_addr == TM16_ADDR_COUNT_LOW);

   // timer tick source selection
   // the tick is registered, so the count steps one cycle after the source edge
   tm16_tick_gen u_tick (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .enable       (enabled),
      .clock_select (control_b_r[TM16_CS_LSB+2 -: 3]),
      .ext_pin      (ext_pin),
      .timer_tick   (timer_tick)
   );

   // top value and counting style per mode
   always_comb begin
      top_value      = TM16_MAX;
      dual_slope     = 1'b0;
      fast_mode      = 1'b0;
      capture_is_top = 1'b0;
      // fixed tops from the package, movable tops from compare a or capture
      case (waveform_mode)
         TM16_WGM_PC8:      begin top_value = TM16_TOP_8;  dual_slope = 1'b1; end
         TM16_WGM_PC9:      begin top_value = TM16_TOP_9;  dual_slope = 1'b1; end
         TM16_WGM_PC10:     begin top_value = TM16_TOP_10; dual_slope = 1'b1; end
         TM16_WGM_CTC_A:    top_value = compare_a_r;
         TM16_WGM_FAST8:    begin top_value = TM16_TOP_8;  fast_mode = 1'b1; end
         TM16_WGM_FAST9:    begin top_value = TM16_TOP_9;  fast_mode = 1'b1; end
         TM16_WGM_FAST10:   begin top_value = TM16_TOP_10; fast_mode = 1'b1; end
         TM16_WGM_PFC_CAP, TM16_WGM_PC_CAP: begin
            top_value = capture_r;
            dual_slope = 1'b1;
            capture_is_top = 1'b1;
         end
         TM16_WGM_PFC_A, TM16_WGM_PC_A: begin
            top_value = compare_a_r;
            dual_slope = 1'b1;
         end
         TM16_WGM_CTC_CAP:  begin top_value = capture_r; capture_is_top = 1'b1; end
         TM16_WGM_FAST_CAP: begin
            top_value = capture_r;
            fast_mode = 1'b1;
            capture_is_top = 1'b1;
         end
         TM16_WGM_FAST_A:   begin top_value = compare_a_r; fast_mode = 1'b1; end
         default:           top_value = TM16_MAX;       // normal and reserved
      endcase
   end

   // control registers carry no access restriction beyond the power-off gate
   // a write here changes source and mode from the next cycle on
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         control_a_r <= TM16_BYTE_RST;
         control_b_r <= TM16_BYTE_RST;
      end else if (enabled && bus_wr) begin
         if (bus_addr == TM16_ADDR_CONTROL_A) begin
            control_a_r <= bus_wdata;
         end
         if (bus_addr == TM16_ADDR_CONTROL_B) begin
            control_b_r <= bus_wdata;
         end
      end
   end

   // shared staging byte: high writes fill it, count and capture low reads refill it
   // one byte for all words: an interleaved access elsewhere corrupts it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         staging_r <= TM16_BYTE_RST;
      end else if (enabled && bus_wr &&
                   (bus_addr == TM16_ADDR_COUNT_HIGH || bus_addr == TM16_ADDR_CAPT_HIGH ||
                    bus_addr == TM16_ADDR_CMPA_HIGH || bus_addr == TM16_ADDR_CMPB_HIGH)) begin
         staging_r <= bus_wdata;
      end else if (enabled && bus_rd) begin
         case (bus_addr)
            TM16_ADDR_COUNT_LOW: staging_r <= count_r[15:8];
            TM16_ADDR_CAPT_LOW:  staging_r <= capture_r[15:8];
            default:             staging_r <= staging_r;            // all other reads, compare included
         endcase
      end
   end

   // compare values load whole on the low-byte write
   // no double buffering: the new word is live in the next cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         compare_a_r <= TM16_WORD_RST;
         compare_b_r <= TM16_WORD_RST;
      end else if (enabled && bus_wr) begin
         if (bus_addr == TM16_ADDR_CMPA_LOW) begin
            compare_a_r <= {staging_r, bus_wdata};
         end
         if (bus_addr == TM16_ADDR_CMPB_LOW) begin
            compare_b_r <= {staging_r, bus_wdata};
         end
      end
   end

   // capture value: host writes only where it defines top
   // events are ignored while capture defines top, so top never jumps
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         capture_r <= TM16_WORD_RST;
      end else if (enabled && bus_wr && capture_is_top &&
                   bus_addr == TM16_ADDR_CAPT_LOW) begin
         capture_r <= {staging_r, bus_wdata};
      end else if (enabled && capture_event && !capture_is_top) begin
         capture_r <= count_r;
      end
   end

   // counter: host write first, otherwise one step per tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_r    <= TM16_WORD_RST;
         dir_down_r <= 1'b0;
         ovf_r      <= 1'b0;
      end else begin
         // overflow is a pulse: it drops unless set again below
         ovf_r <= 1'b0;
         if (wr_count_low) begin
            count_r <= {staging_r, bus_wdata};
         end else if (timer_tick) begin
            // dual slope: up to top, down to bottom, flag at the bottom turn
            if (dual_slope) begin
               if (!dir_down_r) begin
                  if (count_r >= top_value) begin                   // top reached
                     dir_down_r <= 1'b1;
                     count_r    <= top_value - TM16_ONE;
                  end else begin
                     count_r <= count_r + TM16_ONE;
                  end
               end else if (count_r == TM16_BOTTOM) begin
                  dir_down_r <= 1'b0;                               // bottom reached
                  count_r    <= TM16_ONE;
                  ovf_r      <= 1'b1;
               end else begin
                  count_r <= count_r - TM16_ONE;
               end
            end else if (count_r == top_value) begin
               // single slope: clear at top; above a low top it wraps past max
               count_r <= TM16_BOTTOM;                              // clear at top
               ovf_r   <= fast_mode | (top_value == TM16_MAX);
            end else begin
               count_r <= count_r + TM16_ONE;
               ovf_r   <= (count_r == TM16_MAX);                    // wrap above top
            end
         end
         // leaving a dual-slope mode always restarts counting upward
         if (!dual_slope) begin
            dir_down_r <= 1'b0;
         end
      end
   end

   // read mux; high locations of count and capture return the staging byte
   // ignored reads leave the last data standing on the bus
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= TM16_BYTE_RST;
      end else if (enabled && bus_rd) begin
         case (bus_addr)
            TM16_ADDR_CONTROL_A:  rdata_r <= control_a_r;
            TM16_ADDR_CONTROL_B:  rdata_r <= control_b_r;
            TM16_ADDR_COUNT_LOW:  rdata_r <= count_r[7:0];
            TM16_ADDR_COUNT_HIGH: rdata_r <= staging_r;
            TM16_ADDR_CAPT_LOW:   rdata_r <= capture_r[7:0];
            TM16_ADDR_CAPT_HIGH:  rdata_r <= staging_r;
            TM16_ADDR_CMPA_LOW:   rdata_r <= compare_a_r[7:0];
            TM16_ADDR_CMPA_HIGH:  rdata_r <= compare_a_r[15:8];     // direct
            TM16_ADDR_CMPB_LOW:   rdata_r <= compare_b_r[7:0];
            TM16_ADDR_CMPB_HIGH:  rdata_r <= compare_b_r[15:8];     // direct
            default:              rdata_r <= TM16_BYTE_RST;         // unmapped reads zero
         endcase
      end
   end

   // every output is a register, never a combinational path
   assign bus_rdata     = rdata_r;
   assign overflow_flag = ovf_r;
   assign count_value   = count_r;
endmodule
`default_nettype wire

// ### design/tm16_pkg.sv
// constants shared by the 16-bit timer counter core and its tick generator
package tm16_pkg;
   // byte locations on the 8-bit host bus
   localparam logic [3:0] TM16_ADDR_CONTROL_A   = 4'h0;
   localparam logic [3:0] TM16_ADDR_CONTROL_B   = 4'h1;
   localparam logic [3:0] TM16_ADDR_COUNT_LOW   = 4'h4;
   localparam logic [3:0] TM16_ADDR_COUNT_HIGH  = 4'h5;
   localparam logic [3:0] TM16_ADDR_CAPT_LOW    = 4'h6;
   localparam logic [3:0] TM16_ADDR_CAPT_HIGH   = 4'h7;
   localparam logic [3:0] TM16_ADDR_CMPA_LOW    = 4'h8;
   localparam logic [3:0] TM16_ADDR_CMPA_HIGH   = 4'h9;
   localparam logic [3:0] TM16_ADDR_CMPB_LOW    = 4'hA;
   localparam logic [3:0] TM16_ADDR_CMPB_HIGH   = 4'hB;
   // field positions
   localparam int TM16_CS_LSB      = 0;          // clock select in control b
   localparam int TM16_WGM_B_LSB   = 3;          // waveform mode bits 3:2 at bits 4:3 of control b
   localparam int TM16_WGM_A_LSB   = 0;          // waveform mode bits 1:0 in control a
   // reset values
   localparam logic [7:0]  TM16_BYTE_RST  = 8'h00;
   localparam logic [15:0] TM16_WORD_RST  = 16'h0000;
   // counter extremes
   localparam logic [15:0] TM16_BOTTOM    = 16'h0000;
   localparam logic [15:0] TM16_MAX       = 16'hFFFF;
   localparam logic [15:0] TM16_TOP_8     = 16'h00FF;
   localparam logic [15:0] TM16_TOP_9     = 16'h01FF;
   localparam logic [15:0] TM16_TOP_10    = 16'h03FF;
   localparam logic [15:0] TM16_ONE       = 16'h0001;
   // clock select codes
   localparam logic [2:0] TM16_CS_STOP    = 3'h0;
   localparam logic [2:0] TM16_CS_DIV1    = 3'h1;
   localparam logic [2:0] TM16_CS_DIV8    = 3'h2;
   localparam logic [2:0] TM16_CS_DIV64   = 3'h3;
   localparam logic [2:0] TM16_CS_DIV256  = 3'h4;
   localparam logic [2:0] TM16_CS_DIV1024 = 3'h5;
   localparam logic [2:0] TM16_CS_EXT_FALL = 3'h6;
   // prescaler masks (divisor minus one)
   localparam logic [9:0] TM16_PS_M8      = 10'h007;
   localparam logic [9:0] TM16_PS_M64     = 10'h03F;
   localparam logic [9:0] TM16_PS_M256    = 10'h0FF;
   localparam logic [9:0] TM16_PS_M1024   = 10'h3FF;
   localparam logic [9:0] TM16_PS_ONE     = 10'h001;
   localparam logic [9:0] TM16_PS_ZERO    = 10'h000;
   // waveform mode codes
   localparam logic [3:0] TM16_WGM_NORMAL   = 4'h0;
   localparam logic [3:0] TM16_WGM_PC8      = 4'h1;
   localparam logic [3:0] TM16_WGM_PC9      = 4'h2;
   localparam logic [3:0] TM16_WGM_PC10     = 4'h3;
   localparam logic [3:0] TM16_WGM_CTC_A    = 4'h4;
   localparam logic [3:0] TM16_WGM_FAST8    = 4'h5;
   localparam logic [3:0] TM16_WGM_FAST9    = 4'h6;
   localparam logic [3:0] TM16_WGM_FAST10   = 4'h7;
   localparam logic [3:0] TM16_WGM_PFC_CAP  = 4'h8;
   localparam logic [3:0] TM16_WGM_PFC_A    = 4'h9;
   localparam logic [3:0] TM16_WGM_PC_CAP   = 4'hA;
   localparam logic [3:0] TM16_WGM_PC_A     = 4'hB;
   localparam logic [3:0] TM16_WGM_CTC_CAP  = 4'hC;
   localparam logic [3:0] TM16_WGM_FAST_CAP = 4'hE;
   localparam logic [3:0] TM16_WGM_FAST_A   = 4'hF;
endpackage

// ### design/tm16_tick_gen.sv
// timer tick generator: prescaler and external pin edge selection
`timescale 1ns/1ps
`default_nettype none
module tm16_tick_gen
   import tm16_pkg::*;
(
   input  wire logic       ref_clk,        // system clock
   input  wire logic       rst,            // async reset, active high
   input  wire logic       enable,         // module powered
   input  wire logic [2:0] clock_select,   // source select
   input  wire logic       ext_pin,        // external clock pin, synchronous
   output logic            timer_tick      // one-cycle tick enable
);
   logic [9:0] presc_r;                    // free running prescaler
   logic       ext_prev_r;                 // previous external pin level
   logic       tick_r;                     // registered tick

   // prescaler runs while the module is powered
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         presc_r <= TM16_PS_ZERO;
      end else if (enable) begin
         presc_r <= presc_r + TM16_PS_ONE;
      end
   end

   // external edge history
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_pin;
      end
   end

   // source selection; code zero gives no tick at all
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_r <= 1'b0;
      end else if (!enable) begin
         tick_r <= 1'b0;
      end else begin
         case (clock_select)
            TM16_CS_STOP:     tick_r <= 1'b0;
            TM16_CS_DIV1:     tick_r <= 1'b1;
            TM16_CS_DIV8:     tick_r <= (presc_r & TM16_PS_M8) == TM16_PS_M8;
            TM16_CS_DIV64:    tick_r <= (presc_r & TM16_PS_M64) == TM16_PS_M64;
            TM16_CS_DIV256:   tick_r <= (presc_r & TM16_PS_M256) == TM16_PS_M256;
            TM16_CS_DIV1024:  tick_r <= presc_r == TM16_PS_M1024;
            TM16_CS_EXT_FALL: tick_r <= ext_prev_r & ~ext_pin;
            default:          tick_r <= ~ext_prev_r & ext_pin;   // rising edge
         endcase
      end
   end

   assign timer_tick = tick_r;
endmodule
`default_nettype wire

// ### verification/timer16_counter_byte_access_tb.sv
// self-checking bench for the timer counter core driven by the processor model
`timescale 1ns/1ps
`default_nettype none
module timer16_counter_byte_access_tb;
   import tm16_pkg::*;
   logic        ref_clk = 1'b0;       // system clock
   logic        rst = 1'b1;           // reset
   logic        pwr_off = 1'b0;       // power-off control
   logic        ext_pin = 1'b0;       // external timer clock
   logic        cap_ev = 1'b0;        // capture strobe
   logic [3:0]  bus_addr;
   logic        bus_wr;
   logic        bus_rd;
   logic [7:0]  bus_wdata;
   logic [7:0]  bus_rdata;
   logic        ovf;
   logic [15:0] count_value;
   int          bad_count = 0;
   int          total_checks = 0;
   int          seed = 71;
   int          wmod [int];           // words last written, keyed by index of the low location in los
   logic [3:0]  los [3] = '{TM16_ADDR_COUNT_LOW, TM16_ADDR_CMPA_LOW, TM16_ADDR_CMPB_LOW};
   always #2 ref_clk = ~ref_clk;
   tm16_counter_core i_dut (.ref_clk(ref_clk), .rst(rst), .timer_power_off(pwr_off),
      .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
      .ext_pin(ext_pin), .capture_event(cap_ev), .bus_rdata(bus_rdata),
      .overflow_flag(ovf), .count_value(count_value));
   tm16_cpu_model i_cpu (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // single byte access with the bus released afterwards
   task automatic acc(input bit w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      cyc(1);
      i_cpu.op(w, a, d, q);
      i_cpu.idle();
   endtask
   initial begin
      logic [15:0] v;
      logic [15:0] r;
      logic [15:0] prev;
      logic [7:0]  q;
      int          mx;
      int          dn;
      int          dv [4] = '{8, 64, 256, 1024}; // prescaler divisors
      cyc(16);
      rst = 1'b0;
      pwr_off = 1'b1;                            // accesses refused while off
      i_cpu.wr16(TM16_ADDR_COUNT_LOW, 16'h5A5A);
      pwr_off = 1'b0;
      i_cpu.rd16(TM16_ADDR_COUNT_LOW, r);
      chk(r, TM16_WORD_RST);
      for (int i = 0; i < 9; i++) begin          // random words through each location
         v = 16'($random(seed));
         wmod[i % 3] = v;
         i_cpu.wr16(los[i % 3], v);
         i_cpu.rd16(los[i % 3], r);
         chk(r, 16'(wmod[i % 3]));
      end
      chk(count_value, 16'(wmod[0]));
      v = 16'($random(seed));
      i_cpu.wr16(TM16_ADDR_COUNT_LOW, v);
      acc(1'b1, TM16_ADDR_COUNT_HIGH, 8'hC3, q); // stage once, shared by both compares
      cyc(2);
      chk(count_value, v);
      acc(1'b1, TM16_ADDR_CMPA_LOW, 8'h11, q);
      acc(1'b1, TM16_ADDR_CMPB_LOW, 8'h22, q);
      i_cpu.rd16(TM16_ADDR_CMPA_LOW, r);
      chk(r, 16'hC311);
      i_cpu.rd16(TM16_ADDR_CMPB_LOW, r);
      chk(r, 16'hC322);
      acc(1'b0, TM16_ADDR_COUNT_LOW, 8'h00, q);
      acc(1'b0, TM16_ADDR_CMPA_HIGH, 8'h00, q);
      chk({8'h00, q}, 16'h00C3);
      acc(1'b0, 4'hF, 8'h00, q);                 // unmapped location after a nonzero read
      chk({8'h00, q}, 16'h0000);
      acc(1'b0, TM16_ADDR_COUNT_HIGH, 8'h00, q);
      chk({8'h00, q}, {8'h00, v[15:8]});
      cap_ev = 1'b1;
      cyc(1);
      cap_ev = 1'b0;
      i_cpu.rd16(TM16_ADDR_CAPT_LOW, r);
      chk(r, v);
      for (int s = 6; s < 8; s++) begin          // external falling then rising edges
         i_cpu.wr16(TM16_ADDR_COUNT_LOW, 16'h0000);
         acc(1'b1, TM16_ADDR_CONTROL_B, 8'(s), q);
         repeat (5) begin
            ext_pin = 1'b1;
            cyc(3);
            ext_pin = 1'b0;
            cyc(3);
         end
         acc(1'b1, TM16_ADDR_CONTROL_B, {5'h00, TM16_CS_STOP}, q);
         i_cpu.rd16(TM16_ADDR_COUNT_LOW, r);
         chk(r, 16'h0005);
      end
      for (int c = 0; c < 4; c++) begin          // prescaled rates: two ticks in two periods
         i_cpu.wr16(TM16_ADDR_COUNT_LOW, 16'h0000);
         acc(1'b1, TM16_ADDR_CONTROL_B, 8'(c + 2), q);
         cyc(2 * dv[c] - 2);
         acc(1'b1, TM16_ADDR_CONTROL_B, {5'h00, TM16_CS_STOP}, q);
         i_cpu.rd16(TM16_ADDR_COUNT_LOW, r);
         chk(r, 16'h0002);
      end
      acc(1'b1, TM16_ADDR_CONTROL_B, {5'h00, TM16_CS_DIV1}, q);
      i_cpu.wr16(TM16_ADDR_COUNT_LOW, 16'hFFF0); // write while counting
      for (int n = 0; n < 40 && ovf !== 1'b1; n++) cyc(1);
      chk({15'h0000, ovf}, 16'h0001);
      if (ovf !== 1'b1) final_report();
      acc(1'b1, TM16_ADDR_CONTROL_B, {5'h00, TM16_CS_STOP}, q);
      i_cpu.rd16(TM16_ADDR_COUNT_LOW, r);
      chk({8'h00, r[15:8]}, 16'h0000);
      i_cpu.wr16(TM16_ADDR_CMPA_LOW, 16'h0040);
      for (int m = 0; m < 2; m++) begin          // dual-slope 8-bit, then clear on compare a
         acc(1'b1, TM16_ADDR_CONTROL_A, m ? 8'h00 : 8'h01, q);
         i_cpu.wr16(TM16_ADDR_COUNT_LOW, 16'h0000);
         acc(1'b1, TM16_ADDR_CONTROL_B, m ? 8'h09 : 8'h01, q);
         mx = 0;
         dn = 0;
         prev = 16'h0000;
         repeat (600) begin
            cyc(1);
            if (count_value > mx) mx = count_value;
            if (count_value < prev) dn++;
            prev = count_value;
         end
         acc(1'b1, TM16_ADDR_CONTROL_B, {5'h00, TM16_CS_STOP}, q);
         chk(16'(mx), m ? 16'h0040 : TM16_TOP_8);
         chk({15'h0000, dn > 0}, 16'h0001);
      end
      final_report();
   end
endmodule
`default_nettype wire

// ### verification/tm16_core_assertions.sv
// port checker for the timer counter core
`timescale 1ns/1ps
`default_nettype none
module tm16_core_assertions
   import tm16_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        timer_power_off,
   input  wire logic [3:0]  bus_addr,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic [7:0]  bus_rdata,
   input  wire logic        overflow_flag,
   input  wire logic [15:0] count_value
);
   logic [7:0]  ctl_a_r;  // mirror of control a
   logic [7:0]  ctl_b_r;  // mirror of control b
   logic [15:0] cfg_q_r;  // both controls one cycle ago
   logic        stopped;  // no clock source for two cycles
   logic        run1;     // normal mode at full rate, settled
   logic        cnt_wr;   // taken low write of the count
   assign cnt_wr = bus_wr && !timer_power_off && bus_addr == TM16_ADDR_COUNT_LOW;
   assign stopped = ctl_b_r[2:0] == TM16_CS_STOP && cfg_q_r[2:0] == TM16_CS_STOP;
   assign run1 = {ctl_a_r, ctl_b_r} == cfg_q_r && ctl_b_r[2:0] == TM16_CS_DIV1
                 && {ctl_b_r[4:3], ctl_a_r[1:0]} == TM16_WGM_NORMAL && !timer_power_off;
   // track the control bytes the host has written
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctl_a_r <= 8'h00;
         ctl_b_r <= 8'h00;
         cfg_q_r <= 16'h0000;
      end else begin
         if (bus_wr && !timer_power_off && bus_addr == TM16_ADDR_CONTROL_A) ctl_a_r <= bus_wdata;
         if (bus_wr && !timer_power_off && bus_addr == TM16_ADDR_CONTROL_B) ctl_b_r <= bus_wdata;
         cfg_q_r <= {ctl_a_r, ctl_b_r};
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   rdata_hold_a: assert property (!(bus_rd && !timer_power_off) |=> $stable(bus_rdata))
      else $error("read data changed without a read");
   power_rdata_a: assert property (timer_power_off |=> $stable(bus_rdata))
      else $error("read taken while powered off");
   power_count_a: assert property (timer_power_off [*2] |=> $stable(count_value))
      else $error("count moved while powered off");
   word_write_a: assert property (bus_wr && !timer_power_off
      && bus_addr == TM16_ADDR_COUNT_HIGH
      ##1 cnt_wr |=> count_value == {$past(bus_wdata, 2), $past(bus_wdata)})
      else $error("count not loaded from staged and low byte");
   low_read_a: assert property (bus_rd && !timer_power_off
      && bus_addr == TM16_ADDR_COUNT_LOW
      |=> bus_rdata == $past(count_value[7:0]))
      else $error("count low read wrong");
   high_read_a: assert property (bus_rd && !timer_power_off
      && bus_addr == TM16_ADDR_COUNT_LOW
      ##1 bus_rd && !timer_power_off && bus_addr == TM16_ADDR_COUNT_HIGH
      |=> bus_rdata == $past(count_value[15:8], 2))
      else $error("count high read not from staged copy");
   stop_hold_a: assert property (stopped && !cnt_wr |=> $stable(count_value))
      else $error("count changed while stopped");
   step_one_a: assert property (run1 && !cnt_wr
      |=> count_value == $past(count_value) + 16'h0001)
      else $error("count did not step by one");
   wrap_flag_a: assert property (run1 && !cnt_wr && count_value == TM16_MAX
      |-> ##[0:2] overflow_flag)
      else $error("no overflow pulse at wrap");
endmodule
bind tm16_counter_core tm16_core_assertions i_chk (.ref_clk(ref_clk), .rst(rst),
   .timer_power_off(timer_power_off), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .overflow_flag(overflow_flag),
   .count_value(count_value));
`default_nettype wire

// ### verification/tm16_cpu_model.sv
// processor core model issuing byte accesses on the timer host bus
`timescale 1ns/1ps
`default_nettype none
module tm16_cpu_model (
   input  wire logic       ref_clk,    // system clock
   output logic [3:0]      bus_addr,   // byte location
   output logic            bus_wr,     // write strobe
   output logic            bus_rd,     // read strobe
   output logic [7:0]      bus_wdata,  // write data
   input  wire logic [7:0] bus_rdata   // read data
);
   initial begin
      bus_addr = 4'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
   end
   // one byte access: driven just after an edge, taken and answered at the next edge
   task automatic op(input bit w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      bus_addr = a;
      bus_wr = w;
      bus_rd = !w;
      bus_wdata = w ? d : ~bus_wdata;
      @(posedge ref_clk);
      #1;
      q = bus_rdata;
   endtask
   // release: the data and address lines no longer show the last value
   task automatic idle();
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = ~bus_wdata;
      bus_addr = ~bus_addr;
   endtask
   // word tasks run without interleaving, as with interrupts masked
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      logic [7:0] q;
      @(posedge ref_clk);
      #1;
      op(1'b1, lo + 4'h1, v[15:8], q); // high byte first
      op(1'b1, lo, v[7:0], q);         // low byte completes the word
      idle();
   endtask
   task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
      @(posedge ref_clk);
      #1;
      op(1'b0, lo, 8'h00, v[7:0]);          // low byte first
      op(1'b0, lo + 4'h1, 8'h00, v[15:8]);
      idle();
   endtask
endmodule
`default_nettype wire
